/* File: rcr_command_interp.sv */
// text command interpreter with status structures and error replies
//
// Function
// R1 - every received command gets a reply, valid or not; the code sends none for error-free non-query common commands from the bus
// R2 - bad commands answer with the error prefix and a decimal error number
// R3 - 0 success, 1..8 bad numbered argument, 9 unknown, 11 missing argument
// R4 - 18 recognised but unavailable, 27 internal timeout, 28 external timeout
// R5 - mass handler fault puts E in third reply character; fault kept for query
// R6 - an asterisk opens every common command
// R7 - name immediately followed by question mark is a query
// R8 - common commands separate arguments with a space, not equals sign
// R9 - on the instrument bus only common queries are answered; the code answers every bus command except error-free non-query common ones
// R10 - on the primary serial port non-query common commands answer OK
// R11 - common and status commands work on both ports
// R12 - clear zeroes status, event register, error queue, fault, pending completion
// R13 - event enable set takes one decimal mask 0 to 255
// R14 - event enable query returns the mask in decimal
// R15 - only enabled event bits feed the summary bit and service request
// R16 - power-on bit weighs 128, query error bit weighs 4
// R17 - with several bad arguments the lowest numbered one is reported
// R18 - event status query returns decimal contents then clears the register
`timescale 1ns/1ps
module rcr_command_interp #(
	parameter int NAME_BYTES = 8
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// characters from the host, either port
	input rcr_pkg::rcr_rx_type rx,
	output logic rxReady,
	// reply characters to the host
	output rcr_pkg::rcr_tx_type tx,
	input wire logic txReady,
	// instrument side events and conditions
	input wire logic [7:0] eventSet,
	input wire logic pressureReady,
	input wire logic massFault,
	input wire logic [7:0] massFaultCode,
	input wire logic intTimeout,
	input wire logic extTimeout,
	// status structures
	output rcr_pkg::rcr_status_type status
);
	import rcr_pkg::*;

	localparam int NB = NAME_BYTES * 8;
	localparam int RB = REPLY_BYTES * 8;

	// the longest command name must fit the buffer
	if (NAME_BYTES < 6 || NAME_BYTES > 15) begin : g_check
		$error("NAME_BYTES must be 6 to 15");
	end

	typedef struct packed {
		rcr_phase_type state;
		logic [NB-1:0] nameBuf;
		logic [3:0] nameLen;
		logic isCommon;
		logic isQuery;
		logic inArg;
		logic argSeen;
		logic argBad;
		logic [7:0] argVal;
		logic nameBad;
		logic fromBus;
		logic [7:0] ese;
		logic [7:0] esr;
		logic esb;
		logic opcPending;
		logic faultValid;
		logic [7:0] faultCode;
		logic [7:0] lastErr;
		logic [RB-1:0] replyBuf;
		logic [3:0] replyLen;
	} rcr_state_type;

	localparam rcr_state_type ST_RESET = '{state: PH_RECV, esr: ESR_RESET, ese: ESE_RESET, default: '0};

	rcr_state_type cur;
	rcr_state_type nxt;
	rcr_cmd_type cmd;
	logic [7:0] errCode;
	logic silent;
	logic [7:0] decVal;
	logic [23:0] decDigits;
	logic [1:0] decCount;
	logic [9:0] argWide;

	// map a received name to a command
	function automatic rcr_cmd_type decodeCmd(input logic common, input logic [NB-1:0] name);
		rcr_cmd_type c;
		c = CM_UNKNOWN;
		if (common) begin // [R6]
			if (name == NB'(NM_CLEAR)) c = CM_CLEAR;
			else if (name == NB'(NM_EVENT_ENABLE)) c = CM_EVENT_ENABLE;
			else if (name == NB'(NM_EVENT_STATUS)) c = CM_EVENT_STATUS;
			else if (name == NB'(NM_OP_COMPLETE)) c = CM_OP_COMPLETE;
			else if (name == NB'(NM_FACTORY) || name == NB'(NM_SELFTEST) || name == NB'(NM_IDENT) ||
				name == NB'(NM_OPTIONS) || name == NB'(NM_SERVICE) || name == NB'(NM_STATBYTE)) c = CM_NOT_YET;
		end else begin
			if (name == NB'(NM_PRESSURE_READY)) c = CM_PRESSURE_READY;
			else if (name == NB'(NM_MASS_FAULT)) c = CM_MASS_FAULT;
		end
		return c;
	endfunction

	// place up to five bytes, left justified, after the bytes already in the reply
	function automatic logic [RB-1:0] appendBytes(input logic [RB-1:0] buf_, input logic [3:0] len,
		input logic [39:0] bytes);
		logic [RB-1:0] wide;
		wide = {bytes, (RB - 40)'(0)};
		return buf_ | (wide >> (32'(len) * 8));
	endfunction

	rcr_dec_ascii u_dec (
		.value(decVal),
		.digits(decDigits),
		.count(decCount)
	);

	// decode and validate the finished command; the first fault found wins
	always_comb begin
		cmd = decodeCmd(cur.isCommon, cur.nameBuf);
		errCode = ERR_NONE;
		if (cur.nameBad) begin
			errCode = ERR_UNKNOWN; // [R3]
		end else begin
			case (cmd)
				CM_CLEAR: begin
					if (cur.isQuery) errCode = ERR_UNKNOWN;
				end
				CM_EVENT_ENABLE: begin
					// the single argument is argument one, so it is also the lowest bad one
					if (!cur.isQuery && cur.argBad) errCode = ERR_ARG_FIRST; // [R13] [R17]
					else if (!cur.isQuery && !cur.argSeen) errCode = ERR_NO_ARG; // [R3]
				end
				CM_EVENT_STATUS: begin
					if (!cur.isQuery) errCode = ERR_UNKNOWN;
				end
				CM_OP_COMPLETE: errCode = ERR_NONE;
				CM_NOT_YET: errCode = ERR_NOT_YET; // [R4]
				CM_PRESSURE_READY: begin
					if (intTimeout) errCode = ERR_INT_TIMEOUT; // [R4]
				end
				CM_MASS_FAULT: begin
					if (extTimeout) errCode = ERR_EXT_TIMEOUT; // [R4]
				end
				default: errCode = ERR_UNKNOWN; // [R3]
			endcase
		end
		// the bus answers common commands only in query form; errors still answer
		silent = cur.isCommon && !cur.isQuery && cur.fromBus && errCode == ERR_NONE; // [R9]
		if (errCode != ERR_NONE) decVal = errCode;
		else if (cmd == CM_EVENT_ENABLE) decVal = cur.ese;
		else if (cmd == CM_EVENT_STATUS) decVal = cur.esr;
		else decVal = cur.faultCode;
	end

	// parser, executer and reply shifter
	always_comb begin
		nxt = cur;
		argWide = 10'(cur.argVal) * 10'(DEC_BASE) + 10'(rx.data - CH_ZERO);
		case (cur.state)
			PH_RECV: begin
				if (rx.valid) begin
					nxt.fromBus = rx.fromBus; // [R11]
					if (rx.data == CH_CR || rx.data == CH_LF) begin
						// an empty line, such as lf after cr, is not a command
						if (cur.nameLen != 4'h0 || cur.isCommon) nxt.state = PH_EXEC;
					end else if (cur.inArg) begin
						if (rx.data >= CH_ZERO && rx.data <= CH_NINE) begin
							nxt.argSeen = 1'b1;
							if (argWide > 10'(ARG_MAX)) nxt.argBad = 1'b1;
							else nxt.argVal = argWide[7:0];
						end else begin
							nxt.argBad = 1'b1;
						end
					end else if (rx.data == CH_STAR && cur.nameLen == 4'h0 && !cur.isCommon) begin
						nxt.isCommon = 1'b1; // [R6]
					end else if (rx.data == CH_QMARK && cur.nameLen != 4'h0 && !cur.isQuery) begin
						nxt.isQuery = 1'b1; // [R7]
					end else if ((rx.data == CH_SPACE && cur.isCommon) || (rx.data == CH_EQUAL && !cur.isCommon)) begin
						nxt.inArg = 1'b1; // [R8]
						if (cur.isQuery) nxt.nameBad = 1'b1;
					end else if (rx.data == CH_SPACE || rx.data == CH_EQUAL || rx.data == CH_QMARK ||
						cur.isQuery || 32'(cur.nameLen) == NAME_BYTES) begin
						// wrong separator, text after the query mark, or an overlong name
						nxt.nameBad = 1'b1; // [R8]
					end else begin
						nxt.nameBuf = {cur.nameBuf[NB-9:0], rx.data};
						nxt.nameLen = cur.nameLen + 4'h1;
					end
				end
			end
			PH_EXEC: begin
				nxt.replyBuf = '0;
				nxt.replyLen = 4'h0;
				if (errCode != ERR_NONE) begin
					nxt.replyBuf = appendBytes('0, 4'h0, TXT_ERR); // [R2]
					nxt.replyBuf = appendBytes(nxt.replyBuf, 4'h5, {decDigits, 16'h0000});
					nxt.replyLen = 4'h5 + 4'(decCount);
					nxt.lastErr = errCode;
					if (cur.isQuery) nxt.esr[ESR_QYE_BIT] = 1'b1; // [R16]
				end else begin
					case (cmd)
						CM_CLEAR: begin
							nxt.esr = '0; // [R12]
							nxt.opcPending = 1'b0;
							nxt.faultValid = 1'b0;
							nxt.faultCode = '0;
							nxt.lastErr = ERR_NONE;
						end
						CM_EVENT_ENABLE: begin
							if (!cur.isQuery) nxt.ese = cur.argVal; // [R13]
						end
						CM_EVENT_STATUS: nxt.esr = '0; // [R18]
						CM_OP_COMPLETE: begin
							// commands never overlap, so completion is reported a cycle later
							if (!cur.isQuery) nxt.opcPending = 1'b1;
						end
						default: nxt.esr = cur.esr;
					endcase
					if (cmd == CM_PRESSURE_READY) begin
						nxt.replyBuf = appendBytes('0, 4'h0, {pressureReady ? CH_READY : CH_NOTREADY, CH_BLANK,
							cur.faultValid ? CH_FAULT : CH_BLANK, 16'h0000}); // [R5]
						nxt.replyLen = 4'h3;
					end else if (cur.isCommon && !cur.isQuery) begin
						nxt.replyBuf = appendBytes('0, 4'h0, {TXT_OK, 24'h000000}); // [R10]
						nxt.replyLen = 4'h2;
					end else if (cmd == CM_OP_COMPLETE) begin
						nxt.replyBuf = appendBytes('0, 4'h0, {CH_ONE, 32'h00000000});
						nxt.replyLen = 4'h1;
					end else begin
						// enable mask, event status or stored fault code in decimal
						nxt.replyBuf = appendBytes('0, 4'h0, {decDigits, 16'h0000}); // [R14] [R18] [R5]
						nxt.replyLen = 4'(decCount);
					end
				end
				nxt.replyBuf = appendBytes(nxt.replyBuf, nxt.replyLen, {CH_CR, CH_LF, 24'h000000});
				nxt.replyLen = nxt.replyLen + 4'h2;
				nxt.state = silent ? PH_RECV : PH_SEND; // [R1] [R9]
				nxt.nameBuf = '0;
				nxt.nameLen = 4'h0;
				nxt.isCommon = 1'b0;
				nxt.isQuery = 1'b0;
				nxt.inArg = 1'b0;
				nxt.argSeen = 1'b0;
				nxt.argBad = 1'b0;
				nxt.argVal = '0;
				nxt.nameBad = 1'b0;
			end
			PH_SEND: begin
				if (txReady) begin
					nxt.replyBuf = {cur.replyBuf[RB-9:0], 8'h00};
					nxt.replyLen = cur.replyLen - 4'h1;
					if (cur.replyLen == 4'h1) nxt.state = PH_RECV;
				end
			end
			default: nxt.state = PH_RECV;
		endcase
		// pending completion resolves once no command is executing
		if (cur.opcPending && cur.state != PH_EXEC) begin
			nxt.opcPending = 1'b0;
			nxt.esr[ESR_OPC_BIT] = 1'b1;
		end
		// events and faults land after any clear so a simultaneous set is never lost
		nxt.esr = nxt.esr | eventSet; // [R12] [R18]
		if (massFault) begin
			nxt.faultValid = 1'b1; // [R5]
			nxt.faultCode = massFaultCode;
		end
		nxt.esb = |(nxt.esr & nxt.ese); // [R15]
	end

	// state register; power-on bit is set by reset
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cur <= ST_RESET; // [R16]
		end else begin
			cur <= nxt;
		end
	end

	// outputs
	assign rxReady = cur.state == PH_RECV;
	assign tx = '{valid: cur.state == PH_SEND, data: cur.replyBuf[RB-1:RB-8]};
	assign status = '{srq: cur.esb, faultPending: cur.faultValid, eventStatus: cur.esr,
		eventEnable: cur.ese, lastError: cur.lastErr};

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	logic execNow;
	assign execNow = cur.state == PH_EXEC;

	property p_reply_follows;
		execNow && !silent |=> cur.state == PH_SEND ##0 tx.valid;
	endproperty
	a_reply_follows: assert property (p_reply_follows) else $error("command without reply"); // [R1]

	property p_err_prefix;
		execNow && errCode != ERR_NONE |=> cur.replyBuf[RB-1:RB-40] == TXT_ERR && cur.lastErr == $past(errCode);
	endproperty
	a_err_prefix: assert property (p_err_prefix) else $error("error reply lacks prefix or number"); // [R2]

	property p_unknown_code;
		execNow && cmd == CM_UNKNOWN |=> cur.lastErr == ERR_UNKNOWN;
	endproperty
	a_unknown_code: assert property (p_unknown_code) else $error("unknown command not reported as 9"); // [R3]

	property p_int_timeout;
		execNow && cmd == CM_PRESSURE_READY && !cur.nameBad && intTimeout |=> cur.lastErr == ERR_INT_TIMEOUT;
	endproperty
	a_int_timeout: assert property (p_int_timeout) else $error("internal timeout not reported"); // [R4]

	property p_fault_mark;
		execNow && errCode == ERR_NONE && cmd == CM_PRESSURE_READY && cur.faultValid
			|=> cur.replyBuf[RB-17:RB-24] == CH_FAULT;
	endproperty
	a_fault_mark: assert property (p_fault_mark) else $error("fault mark missing in ready reply"); // [R5]

	property p_bus_silent;
		execNow && cur.fromBus && cur.isCommon && !cur.isQuery && errCode == ERR_NONE |=> rxReady && !tx.valid;
	endproperty
	a_bus_silent: assert property (p_bus_silent) else $error("bus answered a non-query common command"); // [R9]

	property p_serial_ok;
		execNow && !cur.fromBus && cur.isCommon && !cur.isQuery && errCode == ERR_NONE
			|=> tx.valid ##0 cur.replyBuf[RB-1:RB-16] == TXT_OK;
	endproperty
	a_serial_ok: assert property (p_serial_ok) else $error("serial port did not acknowledge"); // [R10]

	property p_clear;
		execNow && errCode == ERR_NONE && cmd == CM_CLEAR
			|=> cur.esr == $past(eventSet) && !cur.opcPending && cur.lastErr == ERR_NONE
				&& (!cur.faultValid || $past(massFault));
	endproperty
	a_clear: assert property (p_clear) else $error("clear left status behind"); // [R12]

	property p_enable_load;
		execNow && errCode == ERR_NONE && cmd == CM_EVENT_ENABLE && !cur.isQuery |=> cur.ese == $past(cur.argVal);
	endproperty
	a_enable_load: assert property (p_enable_load) else $error("enable mask not loaded"); // [R13]

	property p_summary;
		status.srq == |(cur.esr & cur.ese);
	endproperty
	a_summary: assert property (p_summary) else $error("summary bit disagrees with enabled events"); // [R15]

	property p_status_read_clears;
		execNow && errCode == ERR_NONE && cmd == CM_EVENT_STATUS && !cur.opcPending
			|=> cur.esr == $past(eventSet);
	endproperty
	a_status_read_clears: assert property (p_status_read_clears) else $error("status read did not clear"); // [R18]

	property p_star_common;
		rxReady && rx.valid && rx.data == CH_STAR && cur.nameLen == 4'h0 && !cur.isCommon |=> cur.isCommon;
	endproperty
	a_star_common: assert property (p_star_common) else $error("asterisk not taken as common prefix"); // [R6]

	c_enable_set: cover property (execNow && cmd == CM_EVENT_ENABLE && !cur.isQuery && errCode == ERR_NONE);
	c_status_read: cover property (execNow && cmd == CM_EVENT_STATUS && errCode == ERR_NONE);
	c_error_reply: cover property (execNow && errCode != ERR_NONE ##1 tx.valid);
	c_fault_ready: cover property (execNow && cmd == CM_PRESSURE_READY && cur.faultValid);

endmodule

/* File: rcr_pkg.sv */
// shared constants, enumerations and carrier structs of the remote command interpreter
package rcr_pkg;

	// reply buffer size in bytes: error prefix, up to three digits, then cr lf
	localparam int REPLY_BYTES = 10;

	// characters the parser and the reply builder use
	localparam logic [7:0] CH_STAR = 8'h2a;
	localparam logic [7:0] CH_QMARK = 8'h3f;
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_EQUAL = 8'h3d;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;
	localparam logic [7:0] CH_ONE = 8'h31;
	localparam logic [7:0] CH_FAULT = 8'h45;
	localparam logic [7:0] CH_READY = 8'h52;
	localparam logic [7:0] CH_NOTREADY = 8'h4e;
	localparam logic [7:0] CH_BLANK = 8'h20;
	localparam logic [15:0] TXT_OK = 16'h4f4b;
	localparam logic [39:0] TXT_ERR = 40'h4552522320;

	// command names, right justified ascii
	localparam logic [47:0] NM_CLEAR = 48'h000000434c53;
	localparam logic [47:0] NM_EVENT_ENABLE = 48'h000000455345;
	localparam logic [47:0] NM_EVENT_STATUS = 48'h000000455352;
	localparam logic [47:0] NM_OP_COMPLETE = 48'h0000004f5043;
	localparam logic [47:0] NM_FACTORY = 48'h000000525354;
	localparam logic [47:0] NM_SELFTEST = 48'h000000545354;
	localparam logic [47:0] NM_IDENT = 48'h00000049444e;
	localparam logic [47:0] NM_OPTIONS = 48'h0000004f5054;
	localparam logic [47:0] NM_SERVICE = 48'h000000535245;
	localparam logic [47:0] NM_STATBYTE = 48'h000000535442;
	localparam logic [47:0] NM_PRESSURE_READY = 48'h000000005052;
	localparam logic [47:0] NM_MASS_FAULT = 48'h414d48455252;

	// error reply numbers
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_ARG_FIRST = 8'h01;
	localparam logic [7:0] ERR_UNKNOWN = 8'h09;
	localparam logic [7:0] ERR_NO_ARG = 8'h0b;
	localparam logic [7:0] ERR_NOT_YET = 8'h12;
	localparam logic [7:0] ERR_INT_TIMEOUT = 8'h1b;
	localparam logic [7:0] ERR_EXT_TIMEOUT = 8'h1c;

	// event status layout and reset values
	localparam int ESR_OPC_BIT = 0;
	localparam int ESR_QYE_BIT = 2;
	localparam int ESR_PON_BIT = 7;
	localparam logic [7:0] ESR_RESET = 8'h80;
	localparam logic [7:0] ESE_RESET = 8'h00;
	localparam logic [7:0] ARG_MAX = 8'hff;
	localparam logic [3:0] DEC_BASE = 4'ha;

	typedef enum logic [1:0] {PH_RECV, PH_EXEC, PH_SEND} rcr_phase_type;
	typedef enum logic [2:0] {CM_CLEAR, CM_EVENT_ENABLE, CM_EVENT_STATUS, CM_OP_COMPLETE,
		CM_NOT_YET, CM_PRESSURE_READY, CM_MASS_FAULT, CM_UNKNOWN} rcr_cmd_type;

	// one received character and the port it came through
	typedef struct packed {
		logic valid;
		logic fromBus;
		logic [7:0] data;
	} rcr_rx_type;

	// one reply character toward the host
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} rcr_tx_type;

	// status structures seen by the rest of the instrument
	typedef struct packed {
		logic srq;
		logic faultPending;
		logic [7:0] eventStatus;
		logic [7:0] eventEnable;
		logic [7:0] lastError;
	} rcr_status_type;

endpackage

/* File: rcr_dec_ascii.sv */
// binary byte to left-justified decimal ascii digits
`timescale 1ns/1ps
module rcr_dec_ascii (
	// value in
	input wire logic [7:0] value,
	// digits out, most significant first, and their count
	output logic [23:0] digits,
	output logic [1:0] count
);
	import rcr_pkg::*;

	logic [3:0] hundreds;
	logic [3:0] tens;
	logic [3:0] ones;

	// split into decimal places; leading zeros are dropped
	always_comb begin
		hundreds = 4'(value / 8'd100);
		tens = 4'((value / 8'(DEC_BASE)) % 8'(DEC_BASE));
		ones = 4'(value % 8'(DEC_BASE));
		if (hundreds != 4'h0) begin
			digits = {CH_ZERO | 8'(hundreds), CH_ZERO | 8'(tens), CH_ZERO | 8'(ones)};
			count = 2'h3;
		end else if (tens != 4'h0) begin
			digits = {CH_ZERO | 8'(tens), CH_ZERO | 8'(ones), 8'h00};
			count = 2'h2;
		end else begin
			digits = {CH_ZERO | 8'(ones), 16'h0000};
			count = 2'h1;
		end
	end

endmodule

/* File: rcr_host_model.sv */
// host computer model: sends command lines and collects reply characters
`timescale 1ns/1ps
module rcr_host_model (
	// clock
	input wire logic clk_sys,
	// characters toward the interpreter
	output rcr_pkg::rcr_rx_type rx,
	input wire logic rxReady,
	// reply characters from the interpreter
	input rcr_pkg::rcr_tx_type tx,
	output logic txReady
);
	import rcr_pkg::*;
	logic slow = 1'b0;
	logic gotEnd = 1'b0;
	logic [95:0] replyBits = '0;
	logic clearReply = 1'b0;

	initial begin
		rx = '0;
	end

	// one line: held characters, then cr; idle data is inverted so a stale value never looks valid
	task automatic send_line(input string s, input logic bus);
		logic [7:0] ch;
		logic taken;
		for (int i = 0; i <= s.len(); i++) begin
			ch = (i == s.len()) ? CH_CR : 8'(s[i]);
			@(negedge clk_sys);
			// the first character of a line wipes the previous reply
			clearReply <= (i == 0);
			rx <= '{valid: 1'b1, fromBus: bus, data: ch};
			taken = 1'b0;
			while (!taken) begin
				taken = (rxReady === 1'b1);
				@(posedge clk_sys);
				if (!taken) @(negedge clk_sys);
			end
		end
		@(negedge clk_sys);
		clearReply <= 1'b0;
		rx <= '{valid: 1'b0, fromBus: bus, data: ~ch};
	endtask

	// collect accepted reply bytes; lf closes the reply
	always @(posedge clk_sys) begin
		if (clearReply) begin
			replyBits <= '0;
			gotEnd <= 1'b0;
		end else if (tx.valid && txReady) begin
			replyBits <= {replyBits[87:0], tx.data};
			gotEnd <= (tx.data == CH_LF);
		end
	end

	// a stalling host accepts only every other cycle
	always @(negedge clk_sys) begin
		txReady <= slow ? ~txReady : 1'b1;
	end
endmodule

/* File: test_rcr_command_interp.sv */
// self-checking testbench of the text command interpreter
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; $display("BAD %s expected %h seen %h", nm, e, g); end end
module test_rcr_command_interp;
	import rcr_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	rcr_rx_type rx;
	logic rxReady;
	rcr_tx_type tx;
	logic txReady;
	logic [7:0] eventSet = 8'h00;
	logic pressureReady = 1'b1;
	logic massFault = 1'b0;
	logic [7:0] massFaultCode = 8'h00;
	logic intTimeout = 1'b0;
	logic extTimeout = 1'b0;
	rcr_status_type status;
	int failures = 0;
	int n_tests = 0;

	always #25 clk_sys = ~clk_sys;

	rcr_command_interp #(.NAME_BYTES(8)) i_dut (.clk_sys(clk_sys), .reset(reset), .rx(rx), .rxReady(rxReady),
		.tx(tx), .txReady(txReady), .eventSet(eventSet), .pressureReady(pressureReady), .massFault(massFault),
		.massFaultCode(massFaultCode), .intTimeout(intTimeout), .extTimeout(extTimeout), .status(status));

	rcr_host_model i_host (.clk_sys(clk_sys), .rx(rx), .rxReady(rxReady), .tx(tx), .txReady(txReady));

	// send one line and compare the whole reply; a silent command waits out the bound
	task automatic run(input string c, input logic bus, input logic [95:0] exp);
		int n;
		i_host.send_line(c, bus);
		n = 0;
		while (i_host.gotEnd !== 1'b1 && n < 80) begin
			@(negedge clk_sys);
			n++;
		end
		repeat (2) @(negedge clk_sys);
		`CHK(c, exp, i_host.replyBits)
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic test_reset();
		`CHK("eventStatus", 8'h80, status.eventStatus)
		`CHK("eventEnable", 8'h00, status.eventEnable)
		`CHK("srq", 1'b0, status.srq)
		`CHK("lastError", 8'h00, status.lastError)
		`CHK("rxReady", 1'b1, rxReady)
		$display("test reset done");
	endtask

	task automatic test_enable();
		run("*ESE 132", 1'b0, "OK\r\n");
		`CHK("eventEnable", 8'h84, status.eventEnable)
		`CHK("srq", 1'b1, status.srq)
		run("*ESE?", 1'b0, "132\r\n");
		$display("test enable done");
	endtask

	task automatic test_event_read();
		run("*ESR?", 1'b0, "128\r\n");
		`CHK("eventStatus", 8'h00, status.eventStatus)
		`CHK("srq", 1'b0, status.srq)
		run("*ESR?", 1'b0, "0\r\n");
		$display("test event read done");
	endtask

	// malformed lines of several kinds, then the query error bit
	task automatic test_errors();
		string c [6] = '{"XYZ", "*ESE 256", "*ESE", "*ESE=5", "*ESE 1x", "*RST?"};
		logic [95:0] e [6] = '{"ERR# 9\r\n", "ERR# 1\r\n", "ERR# 11\r\n", "ERR# 9\r\n", "ERR# 1\r\n", "ERR# 18\r\n"};
		for (int i = 0; i < 6; i++) begin
			run(c[i], 1'b0, e[i]);
		end
		`CHK("eventEnable", 8'h84, status.eventEnable)
		`CHK("lastError", 8'h12, status.lastError)
		`CHK("srq", 1'b1, status.srq)
		run("*ESR?", 1'b0, "4\r\n");
		$display("test errors done");
	endtask

	task automatic test_bus();
		run("*ESE 5", 1'b1, '0);
		`CHK("eventEnable", 8'h05, status.eventEnable)
		run("*ESE?", 1'b1, "5\r\n");
		run("FOO", 1'b1, "ERR# 9\r\n");
		$display("test bus done");
	endtask

	// mass handler fault and timeouts, with a stalling host
	task automatic test_mass();
		i_host.slow = 1'b1;
		pressureReady = 1'b0;
		// ready query and fault query names are given as character codes
		run("\120\122", 1'b0, "N  \r\n");
		@(negedge clk_sys);
		massFault = 1'b1;
		massFaultCode = 8'h25;
		@(negedge clk_sys);
		massFault = 1'b0;
		`CHK("faultPending", 1'b1, status.faultPending)
		run("\120\122", 1'b0, "N E\r\n");
		run("\101\115\110\105\122\122", 1'b0, "37\r\n");
		intTimeout = 1'b1;
		run("\120\122", 1'b0, "ERR# 27\r\n");
		intTimeout = 1'b0;
		extTimeout = 1'b1;
		run("\101\115\110\105\122\122", 1'b0, "ERR# 28\r\n");
		extTimeout = 1'b0;
		pressureReady = 1'b1;
		i_host.slow = 1'b0;
		$display("test mass done");
	endtask

	task automatic test_clear();
		run("*ESE 255", 1'b0, "OK\r\n");
		@(negedge clk_sys);
		eventSet = 8'h20;
		@(negedge clk_sys);
		eventSet = 8'h00;
		@(negedge clk_sys);
		`CHK("srq", 1'b1, status.srq)
		run("*CLS", 1'b0, "OK\r\n");
		`CHK("eventStatus", 8'h00, status.eventStatus)
		`CHK("faultPending", 1'b0, status.faultPending)
		`CHK("lastError", 8'h00, status.lastError)
		`CHK("srq", 1'b0, status.srq)
		$display("test clear done");
	endtask

	task automatic test_opc();
		run("*OPC?", 1'b0, "1\r\n");
		run("*OPC", 1'b0, "OK\r\n");
		run("*ESR?", 1'b0, "1\r\n");
		$display("test opc done");
	endtask

	// reset for five cycles, then the scenarios in order
	initial begin
		repeat (5) @(posedge clk_sys);
		@(negedge clk_sys);
		reset = 1'b0;
		@(negedge clk_sys);
		test_reset();
		test_enable();
		test_event_read();
		test_errors();
		test_bus();
		test_mass();
		test_clear();
		test_opc();
		stop_test();
	end

	// hang guard: roughly forty times the expected run length
	initial begin
		#(50 * 20000);
		failures++;
		stop_test();
	end
endmodule
